// ==== logic/twb_ctrl.sv ====
// two-wire bus controller: ahb-lite registers, master and slave engine
// How it works
// - slave joins only on own address match, or on the general call when gc is set
// - address byte lsb picks receive or transmit
// - scl = clock / (2 * factor * divider)
// - slave address in bits 7:1, bit0 zero
// - data write sends, read gives last received
// - control layout en ie mst tx acknowledge_disable repeat_start 0 0
// - extension: gc, ext, zeros, upper address bits
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "twb_defines.svh"
module twb_ctrl import twb_pkg::*; #(
  parameter int DIV_BASE = `TWB_DIV_BASE
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);
  twb_ctrl_type s;        // registered state
  twb_ctrl_type n;        // next state
  logic         tick;     // quarter-bit tick
  logic         run;      // master sequence active
  logic         scl_rise; // synced scl edges
  logic         scl_fall;
  logic         start_det; // bus conditions from synced pins
  logic         stop_det;
  logic         ap;       // ahb address phase accepted
  logic [7:0]   wd;       // write byte in data phase
  logic [7:0]   clr;      // write-one-to-clear mask
  logic         ev_iif;   // byte or address event
  logic         ev_arb;   // arbitration lost event
  logic [7:0]   byte_in;  // byte completed on this rise
  logic         match;    // own or general-call address

  // ----------------------------------------
  // register read mux, zero for unmapped
  // ----------------------------------------
  function automatic logic [7:0] rd_mux(input logic [4:0] a, input twb_ctrl_type r);
    case (a)
      `TWB_OFF_SADR: rd_mux = r.sadr;
      `TWB_OFF_FREQ: rd_mux = r.freq;
      `TWB_OFF_CTRL: rd_mux = r.ctrl;
      `TWB_OFF_STAT: rd_mux = r.stat;
      `TWB_OFF_DATA: rd_mux = r.dat_rx;
      `TWB_OFF_EXT:  rd_mux = r.ext;
      `TWB_OFF_MASK: rd_mux = r.mask;
      default:       rd_mux = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // timer and edge decode
  // ----------------------------------------
  assign run = s.st inside {TWB_START, TWB_HOLD, TWB_BIT, TWB_MACK, TWB_STOP};

  twb_scl_timer #(.DIV_BASE(DIV_BASE)) u_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .run     (run),
    .freq    (s.freq),
    .tick    (tick)
  );

  // only the second and third sync stages feed logic
  assign scl_rise  = s.scl_s2 & ~s.scl_p;
  assign scl_fall  = ~s.scl_s2 & s.scl_p;
  assign start_det = s.scl_s2 & s.scl_p & s.sda_p & ~s.sda_s2;
  assign stop_det  = s.scl_s2 & s.scl_p & ~s.sda_p & s.sda_s2;
  assign ap        = hsel & htrans[1] & hready;
  assign wd        = hwdata[7:0];
  assign byte_in   = {s.shreg[6:0], s.sda_s2};
  // ten-bit matching is not done; extension bits other than gc are stored only
  assign match     = (byte_in[7:1] == s.sadr[7:1]) |
                     (s.ext[`TWB_E_GCA] & (byte_in[7:1] == 7'h00));

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    n      = s;
    clr    = 8'h00;
    ev_iif = 1'b0;
    ev_arb = 1'b0;
    // pin synchronisers
    n.scl_s1 = scl_i;
    n.scl_s2 = s.scl_s1;
    n.scl_p  = s.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = s.sda_s1;
    n.sda_p  = s.sda_s2;
    n.mst_p  = s.ctrl[`TWB_C_MST];
    // address phase: zero wait, read data latched for the data phase
    n.ap_wr = ap & hwrite;
    n.ap_adr = haddr[4:0];
    if (ap && !hwrite) begin
      n.hrdata = rd_mux(haddr[4:0], s);
      // in master receive, reading the data register asks for the next byte;
      // not once master select is cleared, or the request would outlive the stop
      if (haddr[4:0] == `TWB_OFF_DATA && s.st == TWB_HOLD && s.ctrl[`TWB_C_MST] && !s.ctrl[`TWB_C_TX]) begin
        n.go = 1'b1;
      end
    end
    // data phase writes
    if (s.ap_wr) begin
      case (s.ap_adr)
        `TWB_OFF_SADR: n.sadr = {wd[7:1], 1'b0};
        `TWB_OFF_FREQ: n.freq = wd;
        `TWB_OFF_CTRL: begin
          n.ctrl = {wd[7:2], 2'b00};
          n.stat[`TWB_S_ADDRESSED_AS_SLAVE] = 1'b0;
        end
        `TWB_OFF_STAT: clr = wd & `TWB_S_W1C;
        `TWB_OFF_DATA: begin
          n.dat_tx = wd;
          n.go = 1'b1;
        end
        `TWB_OFF_EXT:  n.ext = {wd[7:6], 3'b000, wd[2:0]};
        `TWB_OFF_MASK: n.mask = wd;
        default: ;
      endcase
    end
    // bus busy tracks start and stop seen on the wires
    if (start_det) begin
      n.stat[`TWB_S_BUSY] = 1'b1;
    end
    if (stop_det) begin
      n.stat[`TWB_S_BUSY] = 1'b0;
    end
    // master engine advances one quarter per tick
    if (run && tick) begin
      n.qph = s.qph + 2'b01;
    end
    unique case (s.st)
      TWB_IDLE: begin
        if (s.ctrl[`TWB_C_MST] && !s.mst_p && s.ctrl[`TWB_C_EN]) begin
          if (s.stat[`TWB_S_BUSY]) begin
            // bus owned by someone else: give up at once
            ev_arb = 1'b1;
            n.ctrl[`TWB_C_MST] = 1'b0;
          end else begin
            n.st = TWB_START;
            n.qph = 2'b00;
            n.first = 1'b1;
            // a byte queued before master select must not go out by itself
            n.go = s.ap_wr && (s.ap_adr == `TWB_OFF_DATA);
          end
        end else if (start_det && s.ctrl[`TWB_C_EN] && !s.ctrl[`TWB_C_MST]) begin
          n.st = TWB_SADR;
          n.bitcnt = 4'h0;
        end
      end
      TWB_START: begin
        // release sda, release scl, pull sda, pull scl
        if (tick) begin
          unique case (s.qph)
            2'b00: n.sda_oe_n = 1'b1;
            2'b01: n.scl_oe_n = 1'b1;
            2'b10: n.sda_oe_n = 1'b0;
            2'b11: begin
              n.scl_oe_n = 1'b0;
              n.st = TWB_HOLD;
            end
          endcase
        end
      end
      TWB_HOLD: begin
        // scl held low until software acts
        n.qph = 2'b00;
        if (!s.ctrl[`TWB_C_MST]) begin
          n.st = TWB_STOP;
        end else if (s.ctrl[`TWB_C_REPEAT_START]) begin
          n.ctrl[`TWB_C_REPEAT_START] = 1'b0;
          n.first = 1'b1;
          n.st = TWB_START;
        end else if (s.go) begin
          n.go = 1'b0;
          n.st = TWB_BIT;
          n.bitcnt = 4'h0;
          n.stat[`TWB_S_TCF] = 1'b0;
          n.btx = s.first | s.ctrl[`TWB_C_TX];
          n.shreg = (s.first | s.ctrl[`TWB_C_TX]) ? s.dat_tx : 8'hFF;
          if (s.first) begin
            n.ctrl[`TWB_C_TX] = ~s.dat_tx[0];
          end
        end
      end
      TWB_BIT: begin
        if (tick) begin
          unique case (s.qph)
            2'b00: n.sda_oe_n = s.shreg[7];
            2'b01: n.scl_oe_n = 1'b1;
            2'b10: begin
              if (!s.scl_s2) begin
                n.qph = s.qph; // slave stretches scl
              end else if (s.btx && s.shreg[7] && !s.sda_s2) begin
                // someone else pulled a released line low
                ev_arb = 1'b1;
                n.ctrl[`TWB_C_MST] = 1'b0;
                n.scl_oe_n = 1'b1;
                n.sda_oe_n = 1'b1;
                n.st = TWB_IDLE;
              end else begin
                n.shreg = byte_in;
              end
            end
            2'b11: begin
              n.scl_oe_n = 1'b0;
              n.bitcnt = s.bitcnt + 4'h1;
              if (s.bitcnt == 4'h7) begin
                n.st = TWB_MACK;
              end
            end
          endcase
        end
      end
      TWB_MACK: begin
        if (tick) begin
          unique case (s.qph)
            2'b00: n.sda_oe_n = s.btx | s.ctrl[`TWB_C_ACKNOWLEDGE_DISABLE];
            2'b01: n.scl_oe_n = 1'b1;
            2'b10: begin
              if (!s.scl_s2) begin
                n.qph = s.qph;
              end else if (s.btx) begin
                n.stat[`TWB_S_RECEIVED_ACKNOWLEDGE] = s.sda_s2;
              end
            end
            2'b11: begin
              n.scl_oe_n = 1'b0;
              n.first = 1'b0;
              n.stat[`TWB_S_TCF] = 1'b1;
              ev_iif = 1'b1;
              if (!s.btx) begin
                n.dat_rx = s.shreg;
              end
              n.st = TWB_HOLD;
            end
          endcase
        end
      end
      TWB_STOP: begin
        // pull sda, release scl, release sda
        if (tick) begin
          unique case (s.qph)
            2'b00: n.sda_oe_n = 1'b0;
            2'b01: n.scl_oe_n = 1'b1;
            2'b10: n.sda_oe_n = 1'b1;
            2'b11: n.st = TWB_IDLE;
          endcase
        end
      end
      TWB_SADR: begin
        if (scl_rise) begin
          n.shreg = byte_in;
          n.bitcnt = s.bitcnt + 4'h1;
          if (s.bitcnt == 4'h7) begin
            n.bitcnt = 4'h0;
            if (match) begin
              n.st = TWB_SACK;
              n.first = 1'b1;
              n.btx = byte_in[0];
              n.stat[`TWB_S_ADDRESSED_AS_SLAVE] = 1'b1;
              n.stat[`TWB_S_SRW] = byte_in[0];
              n.stat[`TWB_S_TCF] = 1'b1;
              ev_iif = 1'b1;
            end else begin
              n.st = TWB_IDLE;
            end
          end
        end
      end
      TWB_SACK: begin
        if (scl_fall && s.bitcnt == 4'h0) begin
          n.bitcnt = 4'h1;
          n.sda_oe_n = s.first ? 1'b0 : (s.btx | s.ctrl[`TWB_C_ACKNOWLEDGE_DISABLE]);
        end else if (scl_rise && s.btx && !s.first) begin
          n.stat[`TWB_S_RECEIVED_ACKNOWLEDGE] = s.sda_s2;
        end else if (scl_fall) begin
          n.bitcnt = 4'h0;
          n.first = 1'b0;
          n.st = TWB_SBYTE;
          n.sda_oe_n = 1'b1;
          n.stat[`TWB_S_TCF] = 1'b0;
          if (s.btx && (s.first || !s.stat[`TWB_S_RECEIVED_ACKNOWLEDGE])) begin
            n.shreg = s.dat_tx;
            n.sda_oe_n = s.dat_tx[7];
          end else if (s.btx) begin
            n.st = TWB_IDLE; // master declined more data
          end
        end
      end
      TWB_SBYTE: begin
        if (scl_rise) begin
          n.shreg = byte_in;
          n.bitcnt = s.bitcnt + 4'h1;
          if (s.bitcnt == 4'h7) begin
            n.bitcnt = 4'h0;
            n.st = TWB_SACK;
            n.stat[`TWB_S_TCF] = 1'b1;
            ev_iif = 1'b1;
            if (!s.btx) begin
              n.dat_rx = byte_in;
            end
          end
        end else if (scl_fall) begin
          n.sda_oe_n = s.btx ? s.shreg[7] : 1'b1;
        end
      end
      default: n.st = TWB_IDLE;
    endcase
    // a start or stop on the wires resets the slave side
    if (s.st inside {TWB_SADR, TWB_SBYTE, TWB_SACK}) begin
      if (stop_det) begin
        n.st = TWB_IDLE;
        n.sda_oe_n = 1'b1;
        n.stat[`TWB_S_ADDRESSED_AS_SLAVE] = 1'b0;
      end else if (start_det) begin
        n.st = TWB_SADR;
        n.bitcnt = 4'h0;
        n.sda_oe_n = 1'b1;
      end
    end
    // disabled module lets go of the bus
    if (!s.ctrl[`TWB_C_EN]) begin
      n.st = TWB_IDLE;
      n.scl_oe_n = 1'b1;
      n.sda_oe_n = 1'b1;
    end
    // sticky flags: a new event wins over a same-cycle clear
    n.stat[`TWB_S_IIF] = (s.stat[`TWB_S_IIF] & ~clr[`TWB_S_IIF]) | ev_iif | ev_arb;
    n.stat[`TWB_S_ARBITRATION_LOST] = (s.stat[`TWB_S_ARBITRATION_LOST] & ~clr[`TWB_S_ARBITRATION_LOST]) | ev_arb;
    n.stat[3] = 1'b0;
    n.irq = s.ctrl[`TWB_C_IE] & (|(n.stat & s.mask));
  end

  // ----------------------------------------
  // state register, frozen while ce is low
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s          <= '0;
      s.st       <= TWB_IDLE;
      s.sadr     <= `TWB_RST_REG;
      s.freq     <= `TWB_RST_REG;
      s.ctrl     <= `TWB_RST_REG;
      s.stat     <= `TWB_RST_STAT;
      s.hrdy     <= 1'b1;
      s.scl_oe_n <= 1'b1;
      s.sda_oe_n <= 1'b1;
      s.scl_s1   <= 1'b1;
      s.scl_s2   <= 1'b1;
      s.scl_p    <= 1'b1;
      s.sda_s1   <= 1'b1;
      s.sda_s2   <= 1'b1;
      s.sda_p    <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  // outputs straight from the state register, hresp tied to zero; pins only ever pull low
  assign hrdata    = {24'h000000, s.hrdata};
  assign hreadyout = s.hrdy;
  assign hresp     = 1'b0;
  assign irq       = s.irq;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe_n  = s.scl_oe_n;
  assign sda_oe_n  = s.sda_oe_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ctrl_wr;
    ce && s.ap_wr && s.ap_adr == `TWB_OFF_CTRL |=> s.ctrl[7] == $past(hwdata[7]) && s.ctrl[1:0] == 2'b00;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write wrong");
  property p_sadr_wr;
    ce && s.ap_wr && s.ap_adr == `TWB_OFF_SADR |=> s.sadr == {$past(hwdata[7:1]), 1'b0};
  endproperty
  a_sadr_wr: assert property (p_sadr_wr) else $error("slave address write wrong");
  property p_data_rd;
    ce && ap && !hwrite && haddr[4:0] == `TWB_OFF_DATA |=> hrdata[7:0] == $past(s.dat_rx);
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data read wrong");
  property p_data_wr;
    ce && s.ap_wr && s.ap_adr == `TWB_OFF_DATA |=> s.dat_tx == $past(hwdata[7:0]) && s.go;
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data write not queued");
  property p_stat_rd;
    ce && ap && !hwrite && haddr[4:0] == `TWB_OFF_STAT |=> hrdata[3] == 1'b0 && hrdata[5] == $past(s.stat[5]);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");
  property p_ext_zero;
    s.ext[5:3] == 3'b000;
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("extension reserved bits set");
  property p_slave_join;
    $rose(s.stat[`TWB_S_ADDRESSED_AS_SLAVE]) |-> $past(s.st) == TWB_SADR;
  endproperty
  a_slave_join: assert property (p_slave_join) else $error("addressed without address phase");
  property p_mst_start;
    ce && s.st == TWB_IDLE && s.ctrl[`TWB_C_EN] && s.ctrl[`TWB_C_MST] && !s.mst_p && !s.stat[`TWB_S_BUSY]
      |=> s.st == TWB_START;
  endproperty
  a_mst_start: assert property (p_mst_start) else $error("no start after master select");
  property p_byte_go;
    s.st == TWB_BIT && $past(s.st) == TWB_HOLD |-> $past(s.go);
  endproperty
  a_byte_go: assert property (p_byte_go) else $error("byte began without request");
endmodule
`default_nettype wire

// ==== logic/twb_defines.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef TWB_DEFINES_SVH
`define TWB_DEFINES_SVH
// ----------------------------------------
// register byte offsets (haddr[4:0])
// ----------------------------------------
`define TWB_OFF_SADR 5'h00
`define TWB_OFF_FREQ 5'h04
`define TWB_OFF_CTRL 5'h08
`define TWB_OFF_STAT 5'h0C
`define TWB_OFF_DATA 5'h10
`define TWB_OFF_EXT  5'h14
`define TWB_OFF_MASK 5'h18
// ----------------------------------------
// control_one fields
// ----------------------------------------
`define TWB_C_EN   7
`define TWB_C_IE   6
`define TWB_C_MST  5
`define TWB_C_TX   4
`define TWB_C_ACKNOWLEDGE_DISABLE 3
`define TWB_C_REPEAT_START 2
// ----------------------------------------
// bus_status fields
// ----------------------------------------
`define TWB_S_TCF  7
`define TWB_S_ADDRESSED_AS_SLAVE 6
`define TWB_S_BUSY 5
`define TWB_S_ARBITRATION_LOST 4
`define TWB_S_SRW  2
`define TWB_S_IIF  1
`define TWB_S_RECEIVED_ACKNOWLEDGE 0
`define TWB_S_W1C  8'h12
// ----------------------------------------
// address_extension fields
// ----------------------------------------
`define TWB_E_GCA  7
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TWB_RST_REG  8'h00
`define TWB_RST_STAT 8'h00
`define TWB_DIV_BASE 20
`endif

// ==== logic/twb_pkg.sv ====
// types shared by the two-wire bus controller files
`default_nettype none
package twb_pkg;
  // one-hot engine states
  typedef enum logic [8:0] {
    TWB_IDLE  = 9'h001,
    TWB_START = 9'h002,
    TWB_HOLD  = 9'h004,
    TWB_BIT   = 9'h008,
    TWB_MACK  = 9'h010,
    TWB_STOP  = 9'h020,
    TWB_SADR  = 9'h040,
    TWB_SBYTE = 9'h080,
    TWB_SACK  = 9'h100
  } twb_state_type;
  // whole state of the controller
  typedef struct packed {
    twb_state_type st;
    logic [7:0]    sadr, freq, ctrl, ext, mask, stat;
    logic [7:0]    dat_tx, dat_rx, shreg, hrdata;
    logic [3:0]    bitcnt;
    logic [1:0]    qph;
    logic [4:0]    ap_adr;
    logic          ap_wr, hrdy, irq;
    logic          scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
    logic          scl_oe_n, sda_oe_n, go, mst_p, first, btx;
  } twb_ctrl_type;
  // state of the quarter-bit timer
  typedef struct packed {
    logic [9:0] cnt;
  } twb_tmr_type;
endpackage
`default_nettype wire

// ==== logic/twb_scl_timer.sv ====
// quarter-bit tick generator for the serial clock
`timescale 1ns/10ps
`default_nettype none
`include "twb_defines.svh"
module twb_scl_timer import twb_pkg::*; #(
  parameter int DIV_BASE = `TWB_DIV_BASE
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [7:0] freq,
  output logic            tick
);
  twb_tmr_type s;  // registered state
  twb_tmr_type n;  // next state

  // ----------------------------------------
  // quarter period = factor * divider / 2
  // ----------------------------------------
  function automatic logic [9:0] quarter(input logic [7:0] f);
    logic [2:0]  m;
    logic [7:0]  d;
    logic [10:0] p;
    m = (f[7:6] == 2'b01) ? 3'h2 : (f[7:6] == 2'b10) ? 3'h4 : 3'h1;
    d = 8'(DIV_BASE) + {1'b0, f[5:0], 1'b0};
    p = {8'h00, m} * {3'h0, d};
    return p[10:1];
  endfunction

  // tick when the down counter empties; four ticks make one scl period
  assign tick = run & (s.cnt == 10'h000);

  // reload on tick, idle at zero so the first tick comes at once
  always_comb begin
    n = s;
    if (!run) begin
      n.cnt = 10'h000;
    end else if (tick) begin
      n.cnt = quarter(freq) - 10'h001;
    end else begin
      n.cnt = s.cnt - 10'h001;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // every tick reloads a full quarter, so no divider setting can shorten a phase
  property p_tick_gap;
    ce && tick |=> s.cnt == quarter($past(freq)) - 10'h001;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("scl quarter reload wrong");
endmodule
`default_nettype wire

// ==== verif/twb_peer.sv ====
// peer device on the two-wire bus: addressed slave and simple master
`timescale 1ns/10ps
`default_nettype none
module twb_peer #(
  parameter logic [6:0] ADR = 7'h50 // peer address
) (
  input  wire logic hclk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rel,
  output logic      sda_rel
);
  logic [7:0] rx     = 8'h00; // last byte heard
  logic [7:0] txb    = 8'h3C; // byte sent on reads
  logic       mst_on = 1'b0;  // model owns the clock
  int         cyc    = 0;
  int         t0     = 0;
  int         per    = 0;     // cycles between bit clocks
  int         starts = 0;
  int         stops  = 0;
  // ----------------------------------------
  // framing watch
  // ----------------------------------------
  always @(posedge hclk) cyc <= cyc + 1;
  // ignore the wires settling out of x during reset
  always @(negedge sda) if (scl === 1'b1 && cyc > 4) starts <= starts + 1;
  always @(posedge sda) if (scl === 1'b1 && cyc > 4) stops <= stops + 1;
  // slave side: hear a byte, ack own address, answer reads
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    forever begin
      @(negedge sda iff (scl === 1'b1 && !mst_on));
      for (int i = 0; i < 8; i++) begin
        @(posedge scl);
        if (i == 1) t0 = cyc;
        if (i == 2) per = cyc - t0;
        rx = {rx[6:0], sda};
      end
      if (rx[7:1] == ADR) begin
        @(negedge scl) sda_rel <= 1'b0;
        @(negedge scl);
        // direction taken from the address lsb
        if (rx[0]) for (int i = 7; i >= 0; i--) begin
          sda_rel <= txb[i];
          @(negedge scl);
        end
        sda_rel <= 1'b1; // released line floats to the pull-up
      end
    end
  end
  // master side: start, one byte, ack clock, stop
  task automatic hold();
    repeat (30) @(posedge hclk);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    mst_on = 1'b1;
    sda_rel <= 1'b0;
    hold();
    for (int i = 7; i >= -1; i--) begin
      scl_rel <= 1'b0;
      hold();
      sda_rel <= (i < 0) ? 1'b1 : b[i];
      hold();
      scl_rel <= 1'b1;
      hold();
      if (i < 0) ack = sda;
    end
    scl_rel <= 1'b0;
    hold();
    sda_rel <= 1'b0;
    hold();
    scl_rel <= 1'b1;
    hold();
    sda_rel <= 1'b1;
    hold();
    mst_on = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/two_wire_bus_controller_tb.sv ====
// self-checking bench of the two-wire bus controller
`timescale 1ns/10ps
`default_nettype none
`include "twb_defines.svh"
module two_wire_bus_controller_tb;
  localparam int DIVB = 4;      // short divider base
  logic        hclk, hresetn, hsel, hwrite, scl, sda;
  logic [31:0] haddr, hwdata, hrdata, got;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, irq, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_rel, sda_rel;
  logic [31:0] q[$], mq[$];     // expected value and mask notes
  event        rd_ev;
  int          miscompares = 0;
  int          tests_run   = 0;
  logic [31:0] rs = 32'h3A8CA3C9; // xorshift state
  // ----------------------------------------
  // open-drain wires, pulled up
  // ----------------------------------------
  assign scl = (scl_oe_n ? 1'b1 : scl_o) & scl_rel;
  assign sda = (sda_oe_n ? 1'b1 : sda_o) & sda_rel;
  twb_ctrl #(.DIV_BASE(DIVB)) dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  twb_peer peer (.hclk(hclk), .scl(scl), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    tests_run++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single ahb-lite transfer, held until hready
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= {27'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [31:0] r;
    q.push_back({24'h0, e});
    mq.push_back({24'hFFFFFF, m});
    bus(a, 1'b0, 8'h00, r);
    got = r;
    ->rd_ev;
  endtask
  // bounded wait for the level interrupt
  task automatic wirq();
    for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge hclk);
  endtask
  // read monitor: oldest note against each result
  initial forever begin
    @(rd_ev);
    chk(got, q.pop_front(), mq.pop_front());
  end
  initial begin
    cyc(60000);
    miscompares++;
    conclude();
  end
  initial begin
    logic [31:0] v;
    logic        ack;
    hresetn = 1'b0;
    hsel    = 1'b1;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    cyc(3);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 8; a++) rd(5'(a * 4), 8'h00, 8'hFF);
    chk({31'h0, hresp}, 32'h0, '1);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wr(`TWB_OFF_SADR, v[7:0]);
      wr(`TWB_OFF_EXT, v[15:8]);
      wr(`TWB_OFF_CTRL, v[23:16] & 8'h0B);
      wr(5'h1C, v[31:24]);
      rd(`TWB_OFF_SADR, v[7:0] & 8'hFE, 8'hFF);
      rd(`TWB_OFF_EXT, v[15:8] & 8'hC7, 8'hFF);
      rd(`TWB_OFF_CTRL, v[23:16] & 8'h08, 8'hFF);
      rd(5'h1C, 8'h00, 8'hFF);
    end
    // master transmit of the address byte
    wr(`TWB_OFF_SADR, 8'h6C);
    wr(`TWB_OFF_CTRL, 8'h00);
    wr(`TWB_OFF_FREQ, 8'h41);
    wr(`TWB_OFF_MASK, 8'h00);
    wr(`TWB_OFF_CTRL, 8'hF0);
    cyc(100);
    chk(peer.starts, 32'd1, '1);
    chk({24'h0, peer.rx}, 32'h0, '1);
    wr(`TWB_OFF_DATA, 8'hA0);
    v = 32'h0; // poll from a clean value, not the last random word
    for (int i = 0; i < 300 && v[7] !== 1'b1; i++) bus(`TWB_OFF_STAT, 1'b0, 8'h00, v);
    chk({24'h0, peer.rx}, 32'hA0, '1);
    chk(peer.per, 2 * 2 * (DIVB + 2), '1);
    rd(`TWB_OFF_STAT, 8'hA2, 8'hFF);
    chk({31'h0, irq}, 32'h0, '1);
    wr(`TWB_OFF_MASK, 8'h02);
    cyc(2);
    chk({31'h0, irq}, 32'h1, '1);
    wr(`TWB_OFF_STAT, 8'h12);
    cyc(2);
    chk({31'h0, irq}, 32'h0, '1);
    wr(`TWB_OFF_CTRL, 8'hC0);
    cyc(100);
    chk(peer.stops, 32'd1, '1);
    // master receive of one byte
    wr(`TWB_OFF_CTRL, 8'hF0);
    wr(`TWB_OFF_DATA, 8'hA1);
    wirq();
    rd(`TWB_OFF_CTRL, 8'hE0, 8'hFF);
    wr(`TWB_OFF_STAT, 8'h12);
    rd(`TWB_OFF_DATA, 8'h00, 8'h00);
    wirq();
    wr(`TWB_OFF_CTRL, 8'hC0);
    rd(`TWB_OFF_DATA, 8'h3C, 8'hFF);
    // slave: foreign address ignored, own one answered
    wr(`TWB_OFF_STAT, 8'h12);
    cyc(100);
    peer.send(8'h58, ack);
    chk({31'h0, ack}, 32'h1, '1);
    chk({31'h0, irq}, 32'h0, '1);
    // status read while the peer still holds the bus: the stop clears addressed
    fork
      peer.send(8'h6C, ack);
      begin
        wirq();
        rd(`TWB_OFF_STAT, 8'h42, 8'h4A);
      end
    join
    chk({31'h0, ack}, 32'h0, '1);
    chk({31'h0, irq}, 32'h1, '1);
    conclude();
  end
endmodule
`default_nettype wire
